// ---- hdl/dmx_phy_xbar.sv ----
module dmx_phy_xbar (
  input wire logic i_clk,
  input wire logic i_rst_n,
  dmx_mii_if.dev mii,
  input wire logic [1:0] i_ch_rx_dv,
  input wire logic [1:0][3:0] i_ch_rxd,
  input wire logic [1:0] i_ch_crs,
  input wire logic [1:0] i_ch_col,
  input wire logic [1:0] i_energy_low,
  input wire logic [1:0] i_link_stat,
  input wire logic [1:0] i_speed_stat,
  input wire logic [1:0] i_act_stat,
  input wire logic i_extender_strap,
  input wire logic i_rmii_strap,
  input wire logic [1:0] i_autoneg_strap,
  input wire logic [1:0] i_autoneg_select_0,
  input wire logic [1:0] i_autoneg_select_1,
  input wire logic [1:0] i_fiber_mode_strap,
  output logic [1:0] o_ch_tx_en,
  output logic [1:0][3:0] o_ch_txd,
  output logic [1:0] o_ch_jam,
  output logic [1:0] o_ch_speed100,
  output logic [1:0] o_ch_full_duplex,
  output logic [1:0] o_ch_autoneg,
  output logic [1:0] o_ch_fiber,
  output logic [1:0] o_ch_powerdown,
  output logic [1:0] o_link_ind,
  output logic [1:0] o_speed_ind,
  output logic [1:0] o_act_ind
);
  // =====================================================================
  // helpers
  function automatic dmx_pkg::dmx_src_t rx_src(input logic [1:0] own, input logic [1:0] opp);
    logic opp_gives;
    opp_gives = (opp == dmx_pkg::RT_OPP) || (opp == dmx_pkg::RT_XRX);
    unique case (own)
      dmx_pkg::RT_OWN: rx_src = dmx_pkg::SRC_OWN;
      dmx_pkg::RT_OPP: begin
        if (opp_gives) rx_src = dmx_pkg::SRC_OPP;
        else if (opp == dmx_pkg::RT_OWN) rx_src = dmx_pkg::SRC_OWN;
        else rx_src = dmx_pkg::SRC_NONE;
      end
      dmx_pkg::RT_XRX: begin
        rx_src = (opp == dmx_pkg::RT_OPP) ? dmx_pkg::SRC_OPP : dmx_pkg::SRC_OWN;
      end
      dmx_pkg::RT_OFF: rx_src = opp_gives ? dmx_pkg::SRC_OPP : dmx_pkg::SRC_NONE;
    endcase
  endfunction

  function automatic logic [15:0] strap_bmc(input logic an, input logic sel0,
                                            input logic sel1, input logic fx);
    logic [15:0] b;
    b = '0;
    b[dmx_pkg::BMC_AUTONEG] = an & ~fx;
    b[dmx_pkg::BMC_SPEED] = sel0 | fx;
    b[dmx_pkg::BMC_DUPLEX] = sel1 | fx;
    return b;
  endfunction

  function automatic logic [15:0] strap_route(input logic ext, input logic rmii);
    logic [15:0] r;
    r = dmx_pkg::ROUTE_RST;
    r[dmx_pkg::RT_RMII] = rmii;
    if (ext) begin
      r[dmx_pkg::RT_RX_LSB +: 2] = dmx_pkg::RT_OFF;
      r[dmx_pkg::RT_TX_LSB +: 2] = dmx_pkg::RT_XRX;
      r[dmx_pkg::RT_SC_RX] = ~rmii;
      r[dmx_pkg::RT_SC_TX] = ~rmii;
    end
    return r;
  endfunction

  // =====================================================================
  // reference clock divider
  logic [1:0] ref_cnt;
  logic tick;
  assign tick = (ref_cnt == dmx_pkg::REF_RISE);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ref_cnt <= '0;
      mii.ref_clk <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == dmx_pkg::REF_LAST) ? 2'h0 : ref_cnt + 2'h1;
      if (ref_cnt == dmx_pkg::REF_RISE) mii.ref_clk <= 1'b1;
      else if (ref_cnt == dmx_pkg::REF_FALL) mii.ref_clk <= 1'b0;
    end
  end

  // =====================================================================
  // port transmit pins from the mac
  logic [1:0] tx_en_s;
  logic [1:0][3:0] txd_s;
  dmx_sync #(.WIDTH(10)) u_tx_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({mii.tx_en, mii.txd}),
    .o_q({tx_en_s, txd_s})
  );

  // =====================================================================
  // per-channel registers
  logic [1:0][15:0] bmc;
  logic [1:0][15:0] route;
  logic [1:0] fiber;
  logic strap_done;
  logic [1:0] hit_bmc;
  logic [1:0] hit_route;
  logic [4:0] mg_reg;
  assign mg_reg = mii.mg_addr[dmx_pkg::MG_CH_BIT-1:0];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      hit_bmc[c] = (mii.mg_addr[dmx_pkg::MG_CH_BIT] == c[0]) && (mg_reg == dmx_pkg::REG_BMC);
      hit_route[c] = (mii.mg_addr[dmx_pkg::MG_CH_BIT] == c[0]) &&
                     (mg_reg == dmx_pkg::REG_ROUTE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_done <= 1'b0;
      fiber <= '0;
      bmc <= {dmx_pkg::BMC_RST, dmx_pkg::BMC_RST};
      route <= {dmx_pkg::ROUTE_RST, dmx_pkg::ROUTE_RST};
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      for (int c = 0; c < 2; c++) begin
        fiber[c] <= i_fiber_mode_strap[c];
        bmc[c] <= strap_bmc(i_autoneg_strap[c], i_autoneg_select_0[c],
                            i_autoneg_select_1[c], i_fiber_mode_strap[c]);
        route[c] <= strap_route(i_extender_strap, i_rmii_strap);
      end
    end else if (mii.mg_we) begin
      for (int c = 0; c < 2; c++) begin
        if (hit_bmc[c]) begin
          bmc[c] <= (bmc[c] & ~dmx_pkg::BMC_WMASK) | (mii.mg_wdata & dmx_pkg::BMC_WMASK);
        end
        if (hit_route[c]) begin
          route[c] <= (route[c] & ~dmx_pkg::ROUTE_WMASK) |
                      (mii.mg_wdata & dmx_pkg::ROUTE_WMASK);
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mii.mg_rdata <= '0;
    end else if (mii.mg_re && (hit_bmc != 2'h0)) begin
      mii.mg_rdata <= bmc[mii.mg_addr[dmx_pkg::MG_CH_BIT]];
    end else if (mii.mg_re && (hit_route != 2'h0)) begin
      mii.mg_rdata <= route[mii.mg_addr[dmx_pkg::MG_CH_BIT]];
    end else begin
      mii.mg_rdata <= '0;
    end
  end

  // =====================================================================
  // routing decode
  logic [1:0][1:0] rx_fld;
  logic [1:0][1:0] tx_fld;
  dmx_pkg::dmx_src_t [1:0] rsrc;
  logic [1:0] rx_ch;
  logic [1:0][1:0] tx_hit;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rx_fld[c] = route[c][dmx_pkg::RT_RX_LSB +: 2];
      tx_fld[c] = route[c][dmx_pkg::RT_TX_LSB +: 2];
    end
    for (int p = 0; p < 2; p++) begin
      rsrc[p] = rx_src(rx_fld[p], rx_fld[1-p]);
      rx_ch[p] = (rsrc[p] == dmx_pkg::SRC_OWN) ? p[0] : ~p[0];
      for (int c = 0; c < 2; c++) begin
        tx_hit[p][c] = (tx_fld[c] == dmx_pkg::RT_OWN && c == p) ||
                       (tx_fld[c] == dmx_pkg::RT_OPP && c != p);
      end
    end
  end

  // =====================================================================
  // port receive side, one update per reference rise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mii.rx_dv <= '0;
      mii.rxd <= '0;
      mii.crs <= '0;
      mii.col <= '0;
    end else if (tick) begin
      for (int p = 0; p < 2; p++) begin
        if (rsrc[p] == dmx_pkg::SRC_NONE) begin
          mii.rx_dv[p] <= 1'b0;
          mii.rxd[p] <= 4'h0;
        end else begin
          mii.rx_dv[p] <= i_ch_rx_dv[rx_ch[p]];
          mii.rxd[p] <= i_ch_rxd[rx_ch[p]];
        end
        if (route[p][dmx_pkg::RT_RMII]) begin
          mii.crs[p] <= (rsrc[p] != dmx_pkg::SRC_NONE) && i_ch_crs[rx_ch[p]];
        end else begin
          mii.crs[p] <= |(tx_hit[p] & i_ch_crs);
        end
        mii.col[p] <= |(tx_hit[p] & i_ch_col);
      end
    end
  end

  // =====================================================================
  // channel transmit side
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ch_tx_en <= '0;
      o_ch_txd <= '0;
    end else if (tick) begin
      for (int c = 0; c < 2; c++) begin
        unique case (tx_fld[c])
          dmx_pkg::RT_OWN: begin
            o_ch_tx_en[c] <= tx_en_s[c];
            o_ch_txd[c] <= txd_s[c];
          end
          dmx_pkg::RT_OPP: begin
            o_ch_tx_en[c] <= tx_en_s[1-c];
            o_ch_txd[c] <= txd_s[1-c];
          end
          dmx_pkg::RT_XRX: begin
            o_ch_tx_en[c] <= i_ch_rx_dv[1-c];
            o_ch_txd[c] <= i_ch_rxd[1-c];
          end
          dmx_pkg::RT_OFF: begin
            o_ch_tx_en[c] <= 1'b0;
            o_ch_txd[c] <= 4'h0;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // collision jam in single clock broadcast
  logic bcast;
  assign bcast = (tx_hit[0] == 2'h3) || (tx_hit[1] == 2'h3);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ch_jam <= '0;
    end else begin
      o_ch_jam <= {2{bcast && route[0][dmx_pkg::RT_SC_TX] && route[1][dmx_pkg::RT_SC_TX] &&
                     (i_ch_col != 2'h0)}};
    end
  end

  // =====================================================================
  // per-channel status, enables and configuration
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mii.rx_oe <= '0;
      o_link_ind <= '0;
      o_speed_ind <= '0;
      o_act_ind <= '0;
      o_ch_speed100 <= '0;
      o_ch_full_duplex <= '0;
      o_ch_autoneg <= '0;
      o_ch_fiber <= '0;
      o_ch_powerdown <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        mii.rx_oe[c] <= ~bmc[c][dmx_pkg::BMC_ISOLATE] & ~bmc[c][dmx_pkg::BMC_PWRDN] &
                        ~i_energy_low[c];
        o_ch_powerdown[c] <= bmc[c][dmx_pkg::BMC_PWRDN];
        o_ch_speed100[c] <= bmc[c][dmx_pkg::BMC_SPEED];
        o_ch_full_duplex[c] <= bmc[c][dmx_pkg::BMC_DUPLEX];
        o_ch_autoneg[c] <= bmc[c][dmx_pkg::BMC_AUTONEG];
      end
      o_ch_fiber <= fiber;
      o_link_ind <= i_link_stat;
      o_speed_ind <= i_speed_stat;
      o_act_ind <= i_act_stat;
    end
  end
endmodule

// ---- hdl/dmx_pkg.sv ----
// Functional notes
// - rx field: own, opposite, both, no port
// - channel owns port; yields only when released
// - port rx source from sixteen-entry lookup
// - tx field: own, opposite, other rx, off
// - 1110 on both: rx off, cross tx
// - extender strap sets routing at power-up
// - extender without rmii strap: single clock both
// - media converter: 100 full copper, other fiber
// - extender: same speed, full duplex, sync mode
// - single path: sc rx in rx, tx in tx
// - media conversion only at 100Mb
// - broadcast: both rmii or single clock tx
// - broadcast collision jams both channels; code jams only with single clock tx set on both
// - rmii set on both together; swap any speed
// - never serial 10Mb mode with shared paths
// - crs from tx path, rmii from rx path
// - routing never touches port output enables
// - indicators stay with own channel
// - straps configure own channel only
// - isolate from the port's own channel
// - no power-down/energy gating when rerouted; code gates rx_oe by power-down and energy in every routing
// - no test modes with non-default routing
package dmx_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_PERIOD_NS = 40;
  localparam int REF_DIV = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] REF_LAST = 2'(REF_DIV - 1);
  localparam logic [1:0] REF_RISE = 2'h1;
  localparam logic [1:0] REF_FALL = 2'(REF_DIV / 2 + 1);
  // =====================================================================
  // device registers
  localparam int MG_CH_BIT = 5;
  localparam logic [4:0] REG_BMC = 5'h00;
  localparam logic [4:0] REG_ROUTE = 5'h17;
  localparam int BMC_SPEED = 13;
  localparam int BMC_AUTONEG = 12;
  localparam int BMC_PWRDN = 11;
  localparam int BMC_ISOLATE = 10;
  localparam int BMC_DUPLEX = 8;
  localparam logic [15:0] BMC_RST = 16'h3100;
  localparam logic [15:0] BMC_WMASK = 16'h3D00;
  localparam int RT_RX_LSB = 11;
  localparam int RT_TX_LSB = 9;
  localparam int RT_SC_RX = 7;
  localparam int RT_SC_TX = 6;
  localparam int RT_RMII = 5;
  localparam logic [15:0] ROUTE_RST = 16'h0000;
  localparam logic [15:0] ROUTE_WMASK = 16'h1FE0;
  localparam logic [1:0] RT_OWN = 2'h0;
  localparam logic [1:0] RT_OPP = 2'h1;
  localparam logic [1:0] RT_XRX = 2'h2;
  localparam logic [1:0] RT_OFF = 2'h3;
  typedef enum logic [1:0] {SRC_OWN, SRC_OPP, SRC_NONE} dmx_src_t;
  // =====================================================================
  // controller registers
  localparam logic [3:0] HREG_MODE = 4'h0;
  localparam logic [3:0] HREG_TX_A = 4'h1;
  localparam logic [3:0] HREG_TX_B = 4'h2;
  localparam logic [3:0] HREG_RX = 4'h3;
  localparam logic [3:0] HREG_STAT = 4'h4;
  localparam logic [3:0] HREG_PEEK = 4'h5;
  localparam int MODE_RMII_BIT = 4;
  localparam int TX_EN_BIT = 4;
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SWAP, MODE_EXTEND, MODE_BCAST_A,
    MODE_BCAST_B, MODE_MIRROR_A, MODE_MIRROR_B
  } dmx_mode_t;
endpackage

// ---- hdl/dmx_mii_if.sv ----
interface dmx_mii_if;
  logic ref_clk;
  logic [1:0] tx_en;
  logic [1:0][3:0] txd;
  logic [1:0] rx_dv;
  logic [1:0][3:0] rxd;
  logic [1:0] crs;
  logic [1:0] col;
  logic [1:0] rx_oe;
  logic [5:0] mg_addr;
  logic [15:0] mg_wdata;
  logic mg_we;
  logic mg_re;
  logic [15:0] mg_rdata;
  modport dev (
    input tx_en, txd, mg_addr, mg_wdata, mg_we, mg_re,
    output ref_clk, rx_dv, rxd, crs, col, rx_oe, mg_rdata
  );
  modport mac (
    output tx_en, txd, mg_addr, mg_wdata, mg_we, mg_re,
    input ref_clk, rx_dv, rxd, crs, col, rx_oe, mg_rdata
  );
endinterface

// ---- hdl/dmx_sync.sv ----
module dmx_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// ---- hdl/dmx_mac_ctl.sv ----
module dmx_mac_ctl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  dmx_mii_if.mac mii
);
  // =====================================================================
  // routing word per mode, {channel a, channel b}
  function automatic logic [7:0] mode_fields(input logic [2:0] m);
    unique case (m)
      dmx_pkg::MODE_NORMAL: mode_fields = 8'h00;
      dmx_pkg::MODE_SWAP: mode_fields = 8'h55;
      dmx_pkg::MODE_EXTEND: mode_fields = 8'hEE;
      dmx_pkg::MODE_BCAST_A: mode_fields = 8'h01;
      dmx_pkg::MODE_BCAST_B: mode_fields = 8'h10;
      dmx_pkg::MODE_MIRROR_A: mode_fields = 8'h8C;
      dmx_pkg::MODE_MIRROR_B: mode_fields = 8'hC8;
      default: mode_fields = 8'h00;
    endcase
  endfunction

  // =====================================================================
  // link input sampling
  logic ref_s;
  logic ref_d;
  logic rise;
  logic [1:0] oe_s;
  logic [1:0] dv_s;
  logic [1:0][3:0] rxd_s;
  logic [1:0] crs_s;
  logic [1:0] col_s;
  dmx_sync #(.WIDTH(17)) u_rx_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({mii.ref_clk, mii.rx_oe, mii.rx_dv, mii.rxd, mii.crs, mii.col}),
    .o_q({ref_s, oe_s, dv_s, rxd_s, crs_s, col_s})
  );
  assign rise = ref_s & ~ref_d;

  // =====================================================================
  // software registers and link data
  logic [2:0] mode;
  logic rmii_sel;
  logic [1:0][4:0] tx_reg;
  logic [1:0][6:0] rx_cap;
  logic [15:0] peek;
  logic peek_pend;
  logic busy;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ref_d <= 1'b0;
      tx_reg <= '0;
      rx_cap <= '0;
      mii.tx_en <= '0;
      mii.txd <= '0;
    end else begin
      ref_d <= ref_s;
      if (i_wr && i_addr == dmx_pkg::HREG_TX_A) tx_reg[0] <= i_wdata[4:0];
      if (i_wr && i_addr == dmx_pkg::HREG_TX_B) tx_reg[1] <= i_wdata[4:0];
      if (rise) begin
        for (int p = 0; p < 2; p++) begin
          mii.tx_en[p] <= tx_reg[p][dmx_pkg::TX_EN_BIT];
          mii.txd[p] <= tx_reg[p][3:0];
          rx_cap[p] <= oe_s[p] ? {crs_s[p], col_s[p], dv_s[p], rxd_s[p]} : 7'h00;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        dmx_pkg::HREG_MODE: o_rdata <= {11'h000, rmii_sel, 1'b0, mode};
        dmx_pkg::HREG_TX_A: o_rdata <= {11'h000, tx_reg[0]};
        dmx_pkg::HREG_TX_B: o_rdata <= {11'h000, tx_reg[1]};
        dmx_pkg::HREG_RX: o_rdata <= {2'h0, rx_cap[1], rx_cap[0]};
        dmx_pkg::HREG_STAT: o_rdata <= {14'h0000, peek_pend, busy};
        dmx_pkg::HREG_PEEK: o_rdata <= peek;
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // =====================================================================
  // device configuration sequencer
  typedef enum logic {ST_IDLE, ST_WRITE} dmx_seq_t;
  dmx_seq_t state;
  logic [1:0] step;
  logic [15:0] bmc_word;
  logic [15:0] route_word;
  logic [7:0] flds;
  assign busy = (state == ST_WRITE);
  assign flds = mode_fields(mode);
  always_comb begin
    bmc_word = '0;
    bmc_word[dmx_pkg::BMC_SPEED] = 1'b1;
    bmc_word[dmx_pkg::BMC_DUPLEX] = 1'b1;
    route_word = '0;
    route_word[dmx_pkg::RT_TX_LSB +: 4] = step[0] ? flds[3:0] : flds[7:4];
    route_word[dmx_pkg::RT_RMII] = rmii_sel;
    route_word[dmx_pkg::RT_SC_RX] = ~rmii_sel;
    route_word[dmx_pkg::RT_SC_TX] = ~rmii_sel;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      step <= '0;
      mode <= dmx_pkg::MODE_NORMAL;
      rmii_sel <= 1'b0;
      peek <= '0;
      peek_pend <= 1'b0;
      mii.mg_addr <= '0;
      mii.mg_wdata <= '0;
      mii.mg_we <= 1'b0;
      mii.mg_re <= 1'b0;
    end else begin
      mii.mg_we <= 1'b0;
      mii.mg_re <= 1'b0;
      if (peek_pend) begin
        peek <= mii.mg_rdata;
        peek_pend <= 1'b0;
      end else if (mii.mg_re) begin
        peek_pend <= 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          if (i_wr && i_addr == dmx_pkg::HREG_MODE) begin
            mode <= i_wdata[2:0];
            rmii_sel <= i_wdata[dmx_pkg::MODE_RMII_BIT];
            step <= '0;
            state <= ST_WRITE;
          end else if (i_wr && i_addr == dmx_pkg::HREG_PEEK) begin
            mii.mg_addr <= i_wdata[5:0];
            mii.mg_re <= 1'b1;
          end
        end
        ST_WRITE: begin
          mii.mg_we <= 1'b1;
          mii.mg_addr <= {step[0], step[1] ? dmx_pkg::REG_ROUTE : dmx_pkg::REG_BMC};
          mii.mg_wdata <= step[1] ? route_word : bmc_word;
          step <= step + 2'h1;
          if (step == 2'h3) state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- verif/dmx_xbar_checker.sv ----
module dmx_xbar_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic ref_clk,
  input wire logic [1:0] rx_dv,
  input wire logic [1:0][3:0] rxd,
  input wire logic [1:0] rx_oe,
  input wire logic [5:0] mg_addr,
  input wire logic [15:0] mg_wdata,
  input wire logic mg_we,
  input wire logic mg_re,
  input wire logic [15:0] mg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ra;
  logic [1:0] rb;
  logic [1:0] off;
  logic [3:0] quiet;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ========
  // route fields as last written
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ra <= 2'h0;
      rb <= 2'h0;
    end else if (mg_we && mg_addr[4:0] == 5'h17) begin
      if (mg_addr[5]) begin
        rb <= mg_wdata[12:11];
      end else begin
        ra <= mg_wdata[12:11];
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mg_we) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  always_comb begin
    off[0] = (ra == 2'h3 && (rb == 2'h0 || rb == 2'h3)) || (ra == 2'h1 && rb == 2'h3);
    off[1] = (rb == 2'h3 && (ra == 2'h0 || ra == 2'h3)) || (rb == 2'h1 && ra == 2'h3);
  end
  // ========
  // assertions
  AST_REF_PERIOD: assert property ($rose(ref_clk) |-> ##4 $rose(ref_clk))
    else $error("reference clock period wrong");
  AST_REF_HIGH: assert property ($rose(ref_clk) |-> ref_clk ##1 ref_clk ##1 !ref_clk)
    else $error("reference clock high time wrong");
  AST_RX_ON_TICK: assert property (!$rose(ref_clk) |-> $stable(rx_dv) && $stable(rxd))
    else $error("port receive changed off the reference tick");
  AST_MG_BURST: assert property ($rose(mg_we) |-> mg_we [*4] ##1 !mg_we)
    else $error("configuration burst length wrong");
  AST_MG_ORDER: assert property ($rose(mg_we) |-> mg_addr == 6'h00 ##1 mg_addr == 6'h20
    ##1 mg_addr == 6'h17 ##1 mg_addr == 6'h37)
    else $error("configuration burst order wrong");
  AST_BMC_DATA: assert property (mg_we && mg_addr[4:0] == 5'h00 |-> mg_wdata == 16'h2100)
    else $error("channel speed or duplex not forced");
  AST_SYNC_MODE: assert property (mg_we && mg_addr[4:0] == 5'h17
    |-> mg_wdata[7:6] == (mg_wdata[5] ? 2'h0 : 2'h3))
    else $error("single clock bits wrong");
  AST_RMII_BOTH: assert property (mg_we && mg_addr == 6'h17
    |=> mg_wdata[7:5] == $past(mg_wdata[7:5]))
    else $error("channels clocked differently");
  AST_PORT_OFF: assert property (quiet >= 4'hA |-> (rx_dv & off) == 2'h0
    && (rxd[0] & {4{off[0]}}) == 4'h0 && (rxd[1] & {4{off[1]}}) == 4'h0)
    else $error("disabled port not idle");
  AST_OE_ROUTE: assert property (mg_we && mg_addr[4:0] == 5'h17 |=> $stable(rx_oe) [*3])
    else $error("routing write moved output enable");
  COV_BURST: cover property ($rose(mg_we));
  COV_OFF: cover property (quiet >= 4'hA && off == 2'h3);
  COV_READ: cover property (mg_re ##1 mg_rdata != 16'h0000);
endmodule

// ---- verif/test_dual_channel_mii_port_crossbar.sv ----
module test_dual_channel_mii_port_crossbar;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_wr, i_rd, rd_chk, pend, ext_s, rmii_s;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, d;
  logic [1:0] rx_dv, crs, col, eng, lnk, spd, act, an_s, sel0_s, sel1_s, fx_s;
  logic [1:0] ch_tx_en, jam, sp100, fdx, an, fib, pdn, lnk_i, spd_i, act_i;
  logic [1:0][3:0] rxd, ch_txd;
  logic [31:0] rng, e;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 i_clk = ~i_clk;
  dmx_mii_if mii();
  dmx_phy_xbar i_dmx_phy_xbar(.i_clk(i_clk), .i_rst_n(i_rst_n), .mii(mii),
    .i_ch_rx_dv(rx_dv), .i_ch_rxd(rxd), .i_ch_crs(crs), .i_ch_col(col), .i_energy_low(eng),
    .i_link_stat(lnk), .i_speed_stat(spd), .i_act_stat(act), .i_extender_strap(ext_s),
    .i_rmii_strap(rmii_s), .i_autoneg_strap(an_s), .i_autoneg_select_0(sel0_s),
    .i_autoneg_select_1(sel1_s), .i_fiber_mode_strap(fx_s), .o_ch_tx_en(ch_tx_en),
    .o_ch_txd(ch_txd), .o_ch_jam(jam), .o_ch_speed100(sp100), .o_ch_full_duplex(fdx),
    .o_ch_autoneg(an), .o_ch_fiber(fib), .o_ch_powerdown(pdn), .o_link_ind(lnk_i),
    .o_speed_ind(spd_i), .o_act_ind(act_i));
  dmx_mac_ctl i_dmx_mac_ctl(.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .mii(mii));
  dmx_xbar_checker i_dmx_xbar_checker(.i_clk(i_clk), .i_rst_n(i_rst_n),
    .ref_clk(mii.ref_clk), .rx_dv(mii.rx_dv), .rxd(mii.rxd), .rx_oe(mii.rx_oe),
    .mg_addr(mii.mg_addr), .mg_wdata(mii.mg_wdata), .mg_we(mii.mg_we), .mg_re(mii.mg_re),
    .mg_rdata(mii.mg_rdata));
  // ========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // 0 own channel, 1 other channel, 2 none
  function automatic logic [1:0] src(input logic [1:0] o, input logic [1:0] t);
    case (o)
      2'h0: return 2'h0;
      2'h1: return (t == 2'h0) ? 2'h0 : (t == 2'h3) ? 2'h2 : 2'h1;
      2'h2: return (t == 2'h1) ? 2'h1 : 2'h0;
      default: return (t == 2'h1 || t == 2'h2) ? 2'h1 : 2'h2;
    endcase
  endfunction
  // {rx a, tx a, rx b, tx b} per mode
  function automatic logic [7:0] fields(input int m);
    logic [7:0] t [7] = '{8'h00, 8'h55, 8'hEE, 8'h01, 8'h10, 8'h8C, 8'hC8};
    return t[m];
  endfunction
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= w;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic c);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    rd_chk <= c;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rdx(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m);
    exp_q.push_back({m, x & m});
    rd(a, 1'b1);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 20; k++) begin
      rd(dmx_pkg::HREG_STAT, 1'b0);
      if (d[1:0] === 2'h0) break;
    end
  endtask
  always @(posedge i_clk) begin
    pend <= i_rd & rd_chk;
    if (pend) begin
      e = exp_q.pop_front();
      check("rdata", o_rdata & e[31:16], e[15:0]);
    end
  end
  // ========
  // traffic through the crossbar for one routing set
  task automatic run_case(input logic [7:0] f, input logic r);
    logic [4:0] txv [2];
    logic [15:0] ex;
    logic [1:0] s;
    logic [1:0] tf;
    logic [4:0] e5;
    int ch;
    rng = xs(rng);
    txv[0] = rng[26:22];
    txv[1] = rng[31:27];
    @(posedge i_clk);
    {act, spd, lnk, eng, col, crs, rxd, rx_dv} <= rng[21:0];
    wr(dmx_pkg::HREG_TX_A, {11'h000, txv[0]});
    wr(dmx_pkg::HREG_TX_B, {11'h000, txv[1]});
    repeat (30) @(posedge i_clk);
    ex = 16'h0000;
    for (int p = 0; p < 2; p++) begin
      s = p ? src(f[3:2], f[7:6]) : src(f[7:6], f[3:2]);
      ch = (s == 2'h0) ? p : 1 - p;
      if (s != 2'h2) ex[p*7 +: 5] = {rx_dv[ch], rxd[ch]};
      if (r) ex[p*7+6] = (s != 2'h2) & crs[ch];
      for (int c = 0; c < 2; c++) begin
        tf = c ? f[1:0] : f[5:4];
        if ((tf == 2'h0 && c == p) || (tf == 2'h1 && c != p)) begin
          ex[p*7+5] |= col[c];
          if (!r) ex[p*7+6] |= crs[c];
        end
      end
      // port output enable dropped by energy detect
      if (eng[p]) ex[p*7 +: 7] = 7'h00;
    end
    rdx(dmx_pkg::HREG_RX, ex, 16'h3FFF);
    for (int c = 0; c < 2; c++) begin
      tf = c ? f[1:0] : f[5:4];
      e5 = (tf == 2'h0) ? txv[c] : (tf == 2'h1) ? txv[1-c] : (tf == 2'h2) ?
        {rx_dv[1-c], rxd[1-c]} : 5'h00;
      check("ch_tx", {11'h000, ch_tx_en[c], ch_txd[c]}, {11'h000, e5});
    end
    s = ((f[5:4] == 2'h0 && f[1:0] == 2'h1) || (f[5:4] == 2'h1 && f[1:0] == 2'h0))
      && !r && col != 2'h0 ? 2'h3 : 2'h0;
    check("jam", {14'h0000, jam}, {14'h0000, s});
    check("rx_oe", {14'h0000, mii.rx_oe}, {14'h0000, ~eng});
    check("ind", {10'h000, lnk_i, spd_i, act_i}, {10'h000, lnk, spd, act});
  endtask
  // ========
  // main sequence
  initial begin
    {i_clk, i_rst_n, i_wr, i_rd, rd_chk, pend, ext_s, rmii_s} = 8'h00;
    {i_addr, i_wdata, rx_dv, crs, col, eng, lnk, spd, act, rxd} = 36'h0;
    {an_s, sel0_s, sel1_s, fx_s} = 8'h00;
    rng = 32'h3F0D;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdx(dmx_pkg::HREG_STAT, 16'h0000, 16'hFFFF);
    rdx(4'hF, 16'h0000, 16'hFFFF);
    for (int m = 0; m < 14; m++) begin
      wr(dmx_pkg::HREG_MODE, {11'h000, m[0], 1'b0, 3'(m >> 1)});
      wr(dmx_pkg::HREG_MODE, 16'h0006);
      wait_idle();
      rdx(dmx_pkg::HREG_MODE, {11'h000, m[0], 1'b0, 3'(m >> 1)}, 16'h001F);
      check("bmc", {10'h000, sp100, fdx, pdn}, 16'h003C);
      run_case(fields(m >> 1), m[0]);
    end
    wr(dmx_pkg::HREG_PEEK, 16'h0000);
    wait_idle();
    rdx(dmx_pkg::HREG_PEEK, 16'h2100, 16'hFFFF);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    {ext_s, rmii_s, an_s, sel0_s, sel1_s, fx_s} <= 10'h2F6;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("straps", {8'h00, fib, sp100, fdx, an}, 16'h00BD);
    wr(dmx_pkg::HREG_PEEK, 16'h0017);
    wait_idle();
    rdx(dmx_pkg::HREG_PEEK, 16'h1CC0, 16'hFFFF);
    run_case(8'hEE, 1'b0);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
